// ===== gdio_pkg.sv
// Constants for the general digital I/O port: widths, register map, reset values, field positions
package gdio_pkg;
    localparam int PIN_W = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFF_PIN_IN = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_DIR = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_OUT = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_DIR_SET = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_DIR_CLR = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_OUT_SET = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_OUT_CLR = 4'h7;

    localparam logic [PIN_W-1:0] RST_DIR = 8'h00;
    localparam logic [PIN_W-1:0] RST_OUT = 8'h00;
    localparam logic [PIN_W-1:0] RST_PIN_IN = 8'h00;
    localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;
    localparam logic RST_PUD = 1'b0;

    localparam int CTRL_PUD_BIT = 0;
endpackage : gdio_pkg

// ===== gdio_port.sv
// General digital I/O port: direction, output latch, pull-ups, toggle, synchronised pin input
//
// Contract
// R1 - Direction bit 1 makes the pin an output, 0 an input.
// R2 - Input pin gets pull-up when latch bit is 1 and global disable is 0.
// R3 - Output pin drives the latch bit value; pull-up always off when output.
// R4 - Reset tri-states every pin asynchronously, needing no clock.
// R5 - Writing 1 to a pin input bit inverts its latch bit; 0 does nothing.
// R6 - Pin input register is read-only; output and direction registers are read/write.
// R7 - Global pull-up disable turns off all pull-ups regardless of per-pin bits.
// R8 - Every pin has its own individually selectable pull-up.
// R9 - Single-bit set and clear change one pin without disturbing the others.
// R10 - Alternate function on some pins leaves other pins usable as normal I/O.
// R11 - Software passes tri-state to output high via pull-up input or output low.
// R12 - Software passes pull-up input to output low via tri-state or output high.
// R13 - Pin level readable in any direction through a latch then register synchroniser.
// R14 - Sync latch transparent while clock high, captures on fall, loads on next rise.
// R15 - Software-written pin value appears in pin input bit after one clock period.
// R16 - Software inserts one idle cycle between pin write and pin input read.
// R17 - In deep sleep inputs clamp to ground unless the pin's external interrupt is enabled.
// R18 - A port groups eight pins, one bit per pin at the same position.
`timescale 1ns/1ns
module gdio_port (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [gdio_pkg::ADDR_W-1:0] addr_i,
    input wire logic [gdio_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [gdio_pkg::DATA_W-1:0] rdata_o,
    input wire logic [gdio_pkg::PIN_W-1:0] pad_in_i,
    output logic [gdio_pkg::PIN_W-1:0] pad_out_o,
    output logic [gdio_pkg::PIN_W-1:0] pad_oe_o,
    output logic [gdio_pkg::PIN_W-1:0] pad_pullup_o,
    input wire logic [gdio_pkg::PIN_W-1:0] alt_dir_en_i,
    input wire logic [gdio_pkg::PIN_W-1:0] alt_dir_val_i,
    input wire logic [gdio_pkg::PIN_W-1:0] alt_val_en_i,
    input wire logic [gdio_pkg::PIN_W-1:0] alt_val_i,
    input wire logic sleep_i,
    input wire logic [gdio_pkg::PIN_W-1:0] ext_int_en_i
);
    import gdio_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off, input logic stb);
        hit = stb && (a == off);
    endfunction : hit

    // One bit per pin, at the same position in every pin-wide register; the control register holds a single bit [R18]
    logic [PIN_W-1:0] direction_register_r;
    logic [PIN_W-1:0] output_register_r;
    logic [PIN_W-1:0] pin_input_register_r;
    logic [PIN_W-1:0] sync_latch_r;
    logic global_pullup_disable_r;
    logic [PIN_W-1:0] pad_out_r;
    logic [PIN_W-1:0] pad_oe_r;
    logic [PIN_W-1:0] pad_pullup_r;
    logic [DATA_W-1:0] rdata_r;

    logic [PIN_W-1:0] direction_register_nxt;
    logic [PIN_W-1:0] output_base;
    logic [PIN_W-1:0] output_register_nxt;
    logic global_pullup_disable_nxt;
    logic [PIN_W-1:0] pad_out_nxt;
    logic [PIN_W-1:0] pad_oe_nxt;
    logic [PIN_W-1:0] pad_pullup_nxt;
    logic [PIN_W-1:0] pad_eff;
    logic [DATA_W-1:0] read_sel;
    logic [DATA_W-1:0] rdata_nxt;

    wire wr_pin = hit(addr_i, OFF_PIN_IN, wr_i);
    wire wr_dir = hit(addr_i, OFF_DIR, wr_i);
    wire wr_out = hit(addr_i, OFF_OUT, wr_i);
    wire wr_ctrl = hit(addr_i, OFF_CTRL, wr_i);
    wire wr_dir_set = hit(addr_i, OFF_DIR_SET, wr_i);
    wire wr_dir_clr = hit(addr_i, OFF_DIR_CLR, wr_i);
    wire wr_out_set = hit(addr_i, OFF_OUT_SET, wr_i);
    wire wr_out_clr = hit(addr_i, OFF_OUT_CLR, wr_i);
    wire rd_pin = hit(addr_i, OFF_PIN_IN, rd_i);
    wire rd_dir = hit(addr_i, OFF_DIR, rd_i);
    wire rd_out = hit(addr_i, OFF_OUT, rd_i);
    wire rd_ctrl = hit(addr_i, OFF_CTRL, rd_i);

    // Set/clear ports touch only the bits written as 1 [R9]
    assign direction_register_nxt = wr_dir ? wdata_i :
                                    wr_dir_set ? (direction_register_r | wdata_i) :
                                    wr_dir_clr ? (direction_register_r & ~wdata_i) :
                                    direction_register_r;
    assign output_base = wr_out ? wdata_i :
                         wr_out_set ? (output_register_r | wdata_i) :
                         wr_out_clr ? (output_register_r & ~wdata_i) :
                         output_register_r;
    // Toggle regardless of direction; pin input register stores nothing written [R5] [R6]
    assign output_register_nxt = output_base ^ (wr_pin ? wdata_i : {PIN_W{1'b0}});
    assign global_pullup_disable_nxt = wr_ctrl ? wdata_i[CTRL_PUD_BIT] : global_pullup_disable_r;

    // Pad controls are computed from the next register values so the pads move on the
    // same edge as the registers while still leaving the module straight from flops.
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin
            // Overrides are per pin, so untouched pins keep plain register control [R10]
            assign pad_oe_nxt[gi] = alt_dir_en_i[gi] ? alt_dir_val_i[gi] : direction_register_nxt[gi]; // [R1]
            assign pad_out_nxt[gi] = alt_val_en_i[gi] ? alt_val_i[gi] : output_register_nxt[gi]; // [R3]
            // Per-pin pull-up, off in output mode and under the global disable [R2] [R3] [R7] [R8]
            assign pad_pullup_nxt[gi] = ~pad_oe_nxt[gi] & output_register_nxt[gi] & ~global_pullup_disable_nxt;
            // Clamp ahead of the synchroniser in deep sleep unless the wake interrupt needs it [R17]
            assign pad_eff[gi] = pad_in_i[gi] & ~(sleep_i & ~ext_int_en_i[gi]);
        end
    endgenerate

    assign read_sel = rd_pin ? pin_input_register_r :
                      rd_dir ? direction_register_r :
                      rd_out ? output_register_r :
                      rd_ctrl ? {{(DATA_W-1){1'b0}}, global_pullup_disable_r} :
                      {DATA_W{1'b0}};
    // Data stand only in the cycle after the strobe; unmapped reads return zero
    assign rdata_nxt = rd_i ? read_sel : RST_RDATA;

    // Pads reset asynchronously to tri-state with pull-ups off [R4]
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            direction_register_r <= RST_DIR;
            output_register_r <= RST_OUT;
            global_pullup_disable_r <= RST_PUD;
            pad_oe_r <= RST_DIR;
            pad_out_r <= RST_OUT;
            pad_pullup_r <= RST_OUT;
            rdata_r <= RST_RDATA;
        end else if (ce_i) begin
            direction_register_r <= direction_register_nxt;
            output_register_r <= output_register_nxt;
            global_pullup_disable_r <= global_pullup_disable_nxt;
            pad_oe_r <= pad_oe_nxt; // [R4]
            pad_out_r <= pad_out_nxt;
            pad_pullup_r <= pad_pullup_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Falling-edge stage stands in for the latch that is transparent while the clock is high;
    // it holds the level seen at the fall and feeds only the rising-edge stage [R13] [R14]
    always_ff @(negedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_latch_r <= RST_PIN_IN;
        end else if (ce_i) begin
            sync_latch_r <= pad_eff;
        end
    end

    // A pad driven at a rising edge is seen here at the next one: one period [R14] [R15]
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_input_register_r <= RST_PIN_IN;
        end else if (ce_i) begin
            pin_input_register_r <= sync_latch_r;
        end
    end

    assign rdata_o = rdata_r;
    assign pad_out_o = pad_out_r;
    assign pad_oe_o = pad_oe_r;
    assign pad_pullup_o = pad_pullup_r;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ce_two;
        ce_i [*2];
    endsequence

    sequence s_dir_write;
        ce_i && wr_dir;
    endsequence

    sequence s_toggle_write;
        ce_i && wr_pin;
    endsequence

    a_dir_drives_oe: assert property (s_dir_write |=> // [R1]
        ((pad_oe_o ^ $past(wdata_i)) & ~$past(alt_dir_en_i)) == {PIN_W{1'b0}})
        else $error("direction write not reflected on output enables");

    a_pullup_rule: assert property ($past(ce_i) |-> // [R2]
        ((pad_pullup_o ^ (~direction_register_r & output_register_r & {PIN_W{~global_pullup_disable_r}}))
         & ~$past(alt_dir_en_i)) == {PIN_W{1'b0}})
        else $error("pull-up does not follow direction, latch and global disable");

    a_no_pullup_drive: assert property ((pad_oe_o & pad_pullup_o) == {PIN_W{1'b0}}) // [R3]
        else $error("pull-up active on a driven pin");

    a_reset_tristate: assert property (@(posedge core_clk_i) disable iff (1'b0) // [R4]
        rst_i |-> (pad_oe_o == {PIN_W{1'b0}}) && (pad_pullup_o == {PIN_W{1'b0}}))
        else $error("pins not tri-stated during reset");

    a_toggle_latch: assert property (s_toggle_write |=> // [R5]
        output_register_r == ($past(output_register_r) ^ $past(wdata_i)))
        else $error("pin input write did not toggle the latch");

    a_read_pin_input: assert property (ce_i && rd_pin |=> rdata_o == $past(pin_input_register_r)) // [R6]
        else $error("pin input read data wrong");

    a_pud_global: assert property (global_pullup_disable_r |-> pad_pullup_o == {PIN_W{1'b0}}) // [R7]
        else $error("pull-up on while globally disabled");

    a_bit_set_keep: assert property (ce_i && wr_dir_set |=> // [R9]
        direction_register_r == ($past(direction_register_r) | $past(wdata_i)))
        else $error("direction set disturbed other pins");

    a_alt_isolation: assert property ($past(ce_i) |-> // [R10]
        ((pad_oe_o ^ direction_register_r) & ~$past(alt_dir_en_i)) == {PIN_W{1'b0}})
        else $error("alternate override leaked to another pin");

    a_sync_delay: assert property (s_ce_two |-> pin_input_register_r == $past(pad_eff)) // [R15]
        else $error("pin input not one period behind the pad");

    a_sleep_clamp: assert property (sleep_i |-> (pad_eff & ~ext_int_en_i) == {PIN_W{1'b0}}) // [R17]
        else $error("input not clamped in sleep");

    sequence s_out_set_write;
        ce_i && wr_out_set;
    endsequence

    sequence s_out_clr_write;
        ce_i && wr_out_clr;
    endsequence

    a_dir_write: assert property (ce_i && wr_dir |=> direction_register_r == $past(wdata_i)) // [R1]
        else $error("direction write lost");

    a_dir_clr_keep: assert property (ce_i && wr_dir_clr |=> // [R9]
        direction_register_r == ($past(direction_register_r) & ~$past(wdata_i)))
        else $error("direction clear disturbed other pins");

    a_out_set_keep: assert property (s_out_set_write |=> // [R9]
        output_register_r == ($past(output_register_r) | $past(wdata_i)))
        else $error("latch set disturbed other pins");

    a_out_clr_keep: assert property (s_out_clr_write |=> // [R9]
        output_register_r == ($past(output_register_r) & ~$past(wdata_i)))
        else $error("latch clear disturbed other pins");

    a_dir_keeps_latch: assert property (ce_i && (wr_dir || wr_dir_set || wr_dir_clr) |=> // [R9]
        output_register_r == $past(output_register_r))
        else $error("direction write changed the latch");

    a_latch_keeps_dir: assert property (ce_i && (wr_out || wr_out_set || wr_out_clr) |=> // [R9]
        direction_register_r == $past(direction_register_r))
        else $error("latch write changed the direction");

    a_out_write: assert property (ce_i && wr_out |=> output_register_r == $past(wdata_i)) // [R3]
        else $error("latch write lost");

    a_drive_value: assert property ($past(ce_i) |-> // [R3]
        ((pad_out_o ^ output_register_r) & ~$past(alt_val_en_i)) == {PIN_W{1'b0}})
        else $error("pin drive does not follow the latch");

    a_toggle_dir_keep: assert property (s_toggle_write |=> // [R5]
        direction_register_r == $past(direction_register_r))
        else $error("toggle write changed the direction");

    a_toggle_pud_keep: assert property (s_toggle_write |=> // [R6]
        global_pullup_disable_r == $past(global_pullup_disable_r))
        else $error("toggle write changed the control bit");

    a_read_dir: assert property (ce_i && rd_dir |=> rdata_o == $past(direction_register_r)) // [R6]
        else $error("direction read data wrong");

    a_read_out: assert property (ce_i && rd_out |=> rdata_o == $past(output_register_r)) // [R6]
        else $error("latch read data wrong");

    a_read_idle: assert property (ce_i && !rd_i |=> rdata_o == {DATA_W{1'b0}}) // [R6]
        else $error("read data stands without a read");

    a_read_unmapped: assert property (ce_i && rd_i && (addr_i > OFF_CTRL) |=> rdata_o == {DATA_W{1'b0}}) // [R6]
        else $error("unmapped read returned data");

    a_read_ctrl: assert property (ce_i && rd_ctrl |=> // [R7]
        rdata_o == {{(DATA_W-1){1'b0}}, $past(global_pullup_disable_r)})
        else $error("control read data wrong");

    a_pud_write: assert property (ce_i && wr_ctrl |=> // [R7]
        global_pullup_disable_r == $past(wdata_i[CTRL_PUD_BIT]))
        else $error("global pull-up disable write lost");

    a_alt_dir_value: assert property ($past(ce_i) |-> // [R10]
        ((pad_oe_o ^ $past(alt_dir_val_i)) & $past(alt_dir_en_i)) == {PIN_W{1'b0}})
        else $error("direction override not applied");

    a_alt_drive_value: assert property ($past(ce_i) |-> // [R10]
        ((pad_out_o ^ $past(alt_val_i)) & $past(alt_val_en_i)) == {PIN_W{1'b0}})
        else $error("drive override not applied");

    // The second stage copies only the first; the pad itself is never read twice
    a_sync_stage: assert property (ce_i |=> pin_input_register_r == $past(sync_latch_r)) // [R14]
        else $error("pin input skipped the sync stage");

    // Frozen state keeps the pins steady while the enable is low
    a_ce_freeze: assert property (!ce_i |=> (direction_register_r == $past(direction_register_r))
        && (output_register_r == $past(output_register_r)) && (pad_oe_o == $past(pad_oe_o)))
        else $error("state moved while the clock enable was low");

    a_reset_outputs: assert property (@(posedge core_clk_i) disable iff (1'b0) // [R4]
        rst_i |-> (pad_out_o == {PIN_W{1'b0}}) && (rdata_o == {DATA_W{1'b0}}))
        else $error("outputs not cleared during reset");
endmodule : gdio_port

// ===== gdio_pad_env.sv
// Pad environment model: pin wire resolution with external drivers and floating lines
`timescale 1ns/1ns
module gdio_pad_env (
    input wire logic clk_i,
    input wire logic [gdio_pkg::PIN_W-1:0] out_i,
    input wire logic [gdio_pkg::PIN_W-1:0] oe_i,
    input wire logic [gdio_pkg::PIN_W-1:0] pu_i,
    input wire logic [gdio_pkg::PIN_W-1:0] ext_en_i,
    input wire logic [gdio_pkg::PIN_W-1:0] ext_val_i,
    output logic [gdio_pkg::PIN_W-1:0] pad_o
);
    import gdio_pkg::*;
    logic [PIN_W-1:0] float_r = 8'h00;
    // An undriven line without pull-up toggles so a stale level is never mistaken for data
    always @(posedge clk_i) begin
        float_r <= ~float_r;
    end
    // The device driver wins; the outside releases any pin that the device drives
    assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pu_i | float_r));
endmodule : gdio_pad_env

// ===== gdio_port_test.sv
// Self-checking bench for the general digital I/O port
`timescale 1ns/1ns
module gdio_port_test;
    import gdio_pkg::*;
    typedef struct packed {logic [7:0] ctrl, dir, out, ext, oe, pu;} gdio_row_t;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b0;
    logic ce_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, pad_in, pad_out, pad_oe, pad_pu, d;
    logic [7:0] alt_de = 8'h00, alt_dv = 8'h00, alt_ve = 8'h00, alt_v = 8'h00, int_en = 8'h00;
    logic [7:0] ext_en = 8'hFF, ext_val = 8'h00;
    int num_errors = 0;
    int n_tests = 0;
    gdio_row_t rows [5] = '{{48'h0000_005A_0000}, {48'h0000_A55A_00A5}, {48'h0100_A55A_0000},
        {48'h000F_A55A_0FA0}, {48'h01F0_3C5A_F000}};
    gdio_port gdio_port_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pad_in_i(pad_in),
        .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu), .alt_dir_en_i(alt_de),
        .alt_dir_val_i(alt_dv), .alt_val_en_i(alt_ve), .alt_val_i(alt_v), .sleep_i(sleep_i),
        .ext_int_en_i(int_en));
    gdio_pad_env gdio_pad_env_inst (.clk_i(core_clk_i), .out_i(pad_out), .oe_i(pad_oe), .pu_i(pad_pu),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_in));
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One register per write, so each pin moves one field at a time through a legal midway state
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
        @(posedge core_clk_i) wr_i <= 1'b0;
        @(negedge core_clk_i);
    endtask : wr
    // The wait for the next edge leaves the idle cycle that a loopback read needs
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk_i) {rd_i, addr_i} <= {1'b1, a};
        @(posedge core_clk_i) rd_i <= 1'b0;
        @(negedge core_clk_i) chk(rdata_o, exp);
    endtask : rd
    task automatic results;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        #200000;
        num_errors++;
        results();
    end
    initial begin
        rst_i <= 1'b1;
        @(negedge core_clk_i) chk(pad_oe | pad_pu | pad_out | rdata_o, 8'h00);
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            @(posedge core_clk_i) ext_val <= rows[i].ext;
            wr(OFF_CTRL, rows[i].ctrl);
            wr(OFF_DIR, rows[i].dir);
            wr(OFF_OUT, rows[i].out);
            chk(pad_oe, rows[i].oe);
            chk(pad_out, rows[i].out);
            chk(pad_pu, rows[i].pu);
            rd(OFF_DIR, rows[i].dir);
            rd(OFF_OUT, rows[i].out);
            rd(OFF_CTRL, rows[i].ctrl);
            rd(OFF_PIN_IN, rows[i].dir & rows[i].out | ~rows[i].dir & rows[i].ext);
        end
        // Reset raised between edges must tri-state at once
        #10 rst_i <= 1'b1;
        #1 chk(pad_oe, 8'h00);
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wr(OFF_OUT, 8'h0F);
        wr(OFF_PIN_IN, 8'h3C);
        rd(OFF_OUT, 8'h33);
        wr(OFF_PIN_IN, 8'h00);
        rd(OFF_OUT, 8'h33);
        wr(OFF_DIR_SET, 8'h81);
        wr(OFF_OUT_CLR, 8'h01);
        wr(OFF_OUT_SET, 8'h80);
        wr(OFF_DIR_CLR, 8'h01);
        rd(OFF_DIR, 8'h80);
        rd(OFF_OUT, 8'hB2);
        // Read right behind a pin write still sees the old level; two cycles later the new one
        @(posedge core_clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, OFF_OUT, 8'h32};
        @(posedge core_clk_i) {wr_i, rd_i, addr_i} <= {1'b0, 1'b1, OFF_PIN_IN};
        @(posedge core_clk_i) rd_i <= 1'b0;
        @(negedge core_clk_i) chk(rdata_o, 8'hDA);
        rd(OFF_PIN_IN, 8'h5A);
        @(posedge core_clk_i) {alt_de, alt_dv, alt_ve, alt_v} <= {4{8'h01}};
        repeat (2) @(negedge core_clk_i);
        chk(pad_oe, 8'h81);
        chk(pad_out, 8'h33);
        @(posedge core_clk_i) {alt_de, alt_ve, sleep_i, int_en, ext_val} <= {16'h0000, 1'b1, 16'h02FF};
        rd(OFF_PIN_IN, 8'h02);
        @(posedge core_clk_i) sleep_i <= 1'b0;
        rd(OFF_PIN_IN, 8'h7F);
        // Released lines with pull-up read high, the rest are held low from outside, except pin 7, which the device drives low
        @(posedge core_clk_i) {ext_en, ext_val} <= 16'hCD00;
        rd(OFF_PIN_IN, 8'h32);
        chk(pad_pu, 8'h32);
        wr(4'h9, 8'hFF);
        @(posedge core_clk_i) ce_i <= 1'b0;
        wr(OFF_DIR, 8'h00);
        @(posedge core_clk_i) ce_i <= 1'b1;
        rd(OFF_DIR, 8'h80);
        rd(4'hA, 8'h00);
        rd(OFF_DIR_SET, 8'h00);
        results();
    end
endmodule : gdio_port_test
